// ---- rtl/level_sync.sv ----
// two-stage level synchroniser of configurable width
`timescale 1ns/10ps
`default_nettype none
module level_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  // first stage is read only by the second
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= d_in;
      q_r    <= meta_r;
    end
  end

  assign q_out = q_r;

endmodule
`default_nettype wire

// ---- rtl/relay_card_ctrl.sv ----
// relay output retention, card identity and input edge selection
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - with the retention jumper in keep position, relay outputs hold their state through a host bus reset.
// - with the jumper in default position, a host bus reset clears every relay output.
// - power-on reset clears every relay output whatever the jumper says.
// - the card identity is four switch bits, position one as msb, a closed switch reading 0.
// - with all four identity switches closed the identity reads zero.
// - each input channel has its own rising or falling edge selection, set by software.
// - eight isolated inputs, each asserted by current of either polarity across its terminals.
// - bit 1 connects common to normally-open, bit 0 connects common to normally-closed.
// - a relay that is not retained returns to bit 0, the default open configuration.
module relay_card_ctrl (
  input  wire logic        mclk_in,
  input  wire logic        resetn_in,
  input  wire logic        host_resetn_in,
  input  wire logic        reset_retention_jumper_in,
  input  wire logic [3:0]  card_identity_switch_in,
  input  wire logic [7:0]  isolated_input_terminal_a_in,
  input  wire logic [7:0]  isolated_input_terminal_b_in,
  output logic      [7:0]  relay_normally_open_contact_out,
  output logic      [7:0]  relay_normally_closed_contact_out,
  input  wire logic [7:0]  awaddr_in,
  input  wire logic        awvalid_in,
  output logic             awready_out,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wstrb_in,
  input  wire logic        wvalid_in,
  output logic             wready_out,
  output logic      [1:0]  bresp_out,
  output logic             bvalid_out,
  input  wire logic        bready_in,
  input  wire logic [7:0]  araddr_in,
  input  wire logic        arvalid_in,
  output logic             arready_out,
  output logic      [31:0] rdata_out,
  output logic      [1:0]  rresp_out,
  output logic             rvalid_out,
  input  wire logic        rready_in
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release and field pin synchronisation

  logic                       rst_meta_r;
  logic                       rst_n_r;
  relay_cfg_pkg::field_pins_t pins_raw;
  relay_cfg_pkg::field_pins_t pins_s;
  logic [7:0]                 iso_raw;
  logic [3:0]                 ident;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // an opto pair conducts for either polarity, so both senses count
  assign iso_raw           = isolated_input_terminal_a_in | isolated_input_terminal_b_in;
  assign pins_raw.keep     = reset_retention_jumper_in;
  assign pins_raw.ident_sw = card_identity_switch_in;
  assign pins_raw.iso      = iso_raw;

  level_sync #(
    .WIDTH ($bits(relay_cfg_pkg::field_pins_t))
  ) u_pin_sync (
    .clk_in   (mclk_in),
    .rst_n_in (rst_n_r),
    .d_in     (pins_raw),
    .q_out    (pins_s)
  );

  // closed switch drives its bit high here, and reads back as 0
  assign ident = ~pins_s.ident_sw;

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic                   aw_r,  aw_nxt;
  logic                   w_r,   w_nxt;
  relay_cfg_pkg::wr_req_t req_r, req_nxt;
  logic                   bvalid_r, bvalid_nxt;
  logic [1:0]             bresp_r,  bresp_nxt;
  logic                   rvalid_r, rvalid_nxt;
  logic [31:0]            rdata_r,  rdata_nxt;
  logic [1:0]             rresp_r,  rresp_nxt;
  logic [7:0]             relay_r,  relay_nxt;
  logic [7:0]             nc_r,     nc_nxt;
  logic [7:0]             sel_r,    sel_nxt;
  logic [7:0]             flag_r,   flag_nxt;
  logic [7:0]             prev_r;
  logic [7:0]             iso_event;
  logic                   wr_do;
  logic                   wr_lane0;
  logic [7:0]             wr_addr;
  logic [7:0]             rd_addr;
  logic                   seen_r;

  assign awready_out = host_resetn_in && !aw_r && !bvalid_r;
  assign wready_out  = host_resetn_in && !w_r && !bvalid_r;
  assign arready_out = host_resetn_in && !rvalid_r;
  assign bvalid_out  = bvalid_r;
  assign bresp_out   = bresp_r;
  assign rvalid_out  = rvalid_r;
  assign rdata_out   = rdata_r;
  assign rresp_out   = rresp_r;
  assign relay_normally_open_contact_out   = relay_r;
  assign relay_normally_closed_contact_out = nc_r;

  assign wr_do    = aw_r && w_r && !bvalid_r;
  assign wr_lane0 = wr_do && req_r.strb[0];
  assign wr_addr  = {req_r.addr[7:2], 2'b00};
  assign rd_addr  = {araddr_in[7:2], 2'b00};

  // per-channel edge picked by its select bit: 0 rising, 1 falling
  assign iso_event = (pins_s.iso & ~prev_r & ~sel_r) | (~pins_s.iso & prev_r & sel_r);

  always_comb begin
    aw_nxt     = aw_r;
    w_nxt      = w_r;
    req_nxt    = req_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    relay_nxt  = relay_r;
    sel_nxt    = sel_r;
    flag_nxt   = flag_r | iso_event;
    if (awvalid_in && awready_out) begin
      aw_nxt       = 1'b1;
      req_nxt.addr = awaddr_in;
    end
    if (wvalid_in && wready_out) begin
      w_nxt        = 1'b1;
      req_nxt.data = wdata_in;
      req_nxt.strb = wstrb_in;
    end
    if (wr_do) begin
      aw_nxt     = 1'b0;
      w_nxt      = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = relay_cfg_pkg::RESP_OKAY;
      case (wr_addr)
        relay_cfg_pkg::ADDR_RELAY: begin
          if (wr_lane0) begin
            relay_nxt = req_r.data[7:0];
          end
        end
        relay_cfg_pkg::ADDR_EDGE_SEL: begin
          if (wr_lane0) begin
            sel_nxt = req_r.data[7:0];
          end
        end
        // a new edge in the clearing cycle survives
        relay_cfg_pkg::ADDR_EDGE_FLAG: begin
          if (wr_lane0) begin
            flag_nxt = (flag_r & ~req_r.data[7:0]) | iso_event;
          end
        end
        relay_cfg_pkg::ADDR_INPUT,
        relay_cfg_pkg::ADDR_IDENT: begin
          bresp_nxt = relay_cfg_pkg::RESP_OKAY;
        end
        default: begin
          bresp_nxt = relay_cfg_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (bvalid_r && bready_in) begin
      bvalid_nxt = 1'b0;
    end
    if (rvalid_r && rready_in) begin
      rvalid_nxt = 1'b0;
    end
    if (arvalid_in && arready_out) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = relay_cfg_pkg::RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;
      case (rd_addr)
        relay_cfg_pkg::ADDR_RELAY:     rdata_nxt[7:0] = relay_r;
        relay_cfg_pkg::ADDR_INPUT:     rdata_nxt[7:0] = pins_s.iso;
        relay_cfg_pkg::ADDR_IDENT:     rdata_nxt[relay_cfg_pkg::IDENT_LSB +: relay_cfg_pkg::IDENT_W] = ident;
        relay_cfg_pkg::ADDR_EDGE_SEL:  rdata_nxt[7:0] = sel_r;
        relay_cfg_pkg::ADDR_EDGE_FLAG: rdata_nxt[7:0] = flag_r;
        default:                       rresp_nxt = relay_cfg_pkg::RESP_SLVERR;
      endcase
    end
    // host bus reset: bus side idles, relays follow the jumper
    if (!host_resetn_in) begin
      aw_nxt     = 1'b0;
      w_nxt      = 1'b0;
      bvalid_nxt = 1'b0;
      rvalid_nxt = 1'b0;
      sel_nxt    = relay_cfg_pkg::EDGE_SEL_RESET;
      flag_nxt   = relay_cfg_pkg::EDGE_FLAG_RESET;
      relay_nxt  = pins_s.keep ? relay_r : relay_cfg_pkg::RELAY_RESET;
    end
    nc_nxt = ~relay_nxt;
  end

  always_ff @(posedge mclk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      aw_r     <= 1'b0;
      w_r      <= 1'b0;
      req_r    <= '0;
      bvalid_r <= 1'b0;
      bresp_r  <= relay_cfg_pkg::RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= relay_cfg_pkg::RESP_OKAY;
      relay_r  <= relay_cfg_pkg::RELAY_RESET;
      nc_r     <= ~relay_cfg_pkg::RELAY_RESET;
      sel_r    <= relay_cfg_pkg::EDGE_SEL_RESET;
      flag_r   <= relay_cfg_pkg::EDGE_FLAG_RESET;
      prev_r   <= 8'h00;
      seen_r   <= 1'b0;
    end else begin
      aw_r     <= aw_nxt;
      w_r      <= w_nxt;
      req_r    <= req_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r  <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rresp_nxt;
      relay_r  <= relay_nxt;
      nc_r     <= nc_nxt;
      sel_r    <= sel_nxt;
      flag_r   <= flag_nxt;
      prev_r   <= pins_s.iso;
      seen_r   <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_r);

  sequence s_relay_write;
    wr_lane0 && wr_addr == relay_cfg_pkg::ADDR_RELAY && host_resetn_in;
  endsequence

  property p_keep;
    !host_resetn_in && pins_s.keep |=> relay_r == $past(relay_r);
  endproperty
  a_keep: assert property (p_keep) else $error("relays changed during kept bus reset");

  property p_clear;
    !host_resetn_in && !pins_s.keep |=> relay_r == 8'h00 && nc_r == 8'hFF;
  endproperty
  a_clear: assert property (p_clear) else $error("relays not cleared by bus reset");

  property p_power_on;
    !seen_r |-> relay_normally_open_contact_out == 8'h00;
  endproperty
  a_power_on: assert property (p_power_on) else $error("relays not off after power-on");

  // synchronised switches lag by two edges and the identity reads all ones just after reset
  property p_ident;
    (card_identity_switch_in == $past(card_identity_switch_in)) [*3] ##0 $past(seen_r)
      |-> ident == ~card_identity_switch_in;
  endproperty
  a_ident: assert property (p_ident) else $error("card identity does not follow switches");

  property p_ident_zero;
    (card_identity_switch_in == 4'hF) [*3] ##0 $past(seen_r) |-> ident == 4'h0;
  endproperty
  a_ident_zero: assert property (p_ident_zero) else $error("all switches on must read zero");

  property p_edge;
    (iso_event != 8'h00) && host_resetn_in |=> (flag_r & $past(iso_event)) == $past(iso_event);
  endproperty
  a_edge: assert property (p_edge) else $error("selected input edge not flagged");

  property p_iso;
    // inputs held through reset must not trip this before the synchroniser refills
    (seen_r && iso_raw == $past(iso_raw)) [*2] |-> ##1 pins_s.iso == $past(iso_raw);
  endproperty
  a_iso: assert property (p_iso) else $error("isolated input level not seen");

  property p_contacts;
    relay_normally_closed_contact_out == ~relay_normally_open_contact_out;
  endproperty
  a_contacts: assert property (p_contacts) else $error("relay contact pair inconsistent");

  property p_write;
    s_relay_write |=> relay_r == $past(req_r.data[7:0]) ##0 bvalid_out;
  endproperty
  a_write: assert property (p_write) else $error("relay write not applied");

endmodule
`default_nettype wire

// ---- shared/relay_cfg_pkg.sv ----
// shared constants and carriers for the relay card control block
package relay_cfg_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_RELAY     = 8'h00;
  localparam logic [7:0] ADDR_INPUT     = 8'h04;
  localparam logic [7:0] ADDR_IDENT     = 8'h08;
  localparam logic [7:0] ADDR_EDGE_SEL  = 8'h0C;
  localparam logic [7:0] ADDR_EDGE_FLAG = 8'h10;

  // widths and field layout
  localparam int unsigned CHAN_N    = 8;
  localparam int unsigned IDENT_W   = 4;
  localparam int unsigned IDENT_LSB = 0;

  // reset values
  localparam logic [7:0] RELAY_RESET     = 8'h00;
  localparam logic [7:0] EDGE_SEL_RESET  = 8'h00;
  localparam logic [7:0] EDGE_FLAG_RESET = 8'h00;

  // answers on the register bus
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // field pins, carried together through the synchroniser
  typedef struct packed {
    logic       keep;
    logic [3:0] ident_sw;
    logic [7:0] iso;
  } field_pins_t;

  localparam field_pins_t PINS_RESET = 13'h0000;

  // one held write request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } wr_req_t;

endpackage

// ---- verification/field_side_model.sv ----
// field side: jumper, identity switch and isolated input sources
`timescale 1ns/10ps
`default_nettype none
module field_side_model (
  input  wire logic       keep_sel_in,
  input  wire logic [3:0] ident_value_in,
  input  wire logic [7:0] drive_pos_in,
  input  wire logic [7:0] drive_neg_in,
  output logic            jumper_out,
  output logic      [3:0] switch_out,
  output logic      [7:0] term_a_out,
  output logic      [7:0] term_b_out
);
  assign jumper_out = keep_sel_in;
  // a switch is closed for each 0 bit of the wanted identity
  assign switch_out = ~ident_value_in;
  // reversed polarity conducts through terminal b
  assign term_a_out = drive_pos_in & ~drive_neg_in;
  assign term_b_out = drive_neg_in & ~drive_pos_in;
endmodule
`default_nettype wire

// ---- verification/relay_card_ctrl_tb_top.sv ----
// self-checking bench for the relay card control block
`timescale 1ns/10ps
`default_nettype none
module relay_card_ctrl_tb_top;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] data;
    logic [1:0]  resp;
  } row_t;
  logic mclk_in, resetn_in, host_resetn_in, keep, jmp;
  logic [3:0] ident, sw;
  logic [7:0] pos, neg, ta, tb, no_o, nc_o, awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  int err_total, checks, i;
  row_t rows [8] = '{
    '{1'h1, 8'h00, 32'h0000_00A5, relay_cfg_pkg::RESP_OKAY},
    '{1'h0, 8'h00, 32'h0000_00A5, relay_cfg_pkg::RESP_OKAY},
    '{1'h1, 8'h0C, 32'h0000_000F, relay_cfg_pkg::RESP_OKAY},
    '{1'h0, 8'h0C, 32'h0000_000F, relay_cfg_pkg::RESP_OKAY},
    '{1'h1, 8'h14, 32'h0000_00FF, relay_cfg_pkg::RESP_SLVERR},
    '{1'h0, 8'h14, 32'h0000_0000, relay_cfg_pkg::RESP_SLVERR},
    '{1'h1, 8'h08, 32'h0000_0005, relay_cfg_pkg::RESP_OKAY},
    '{1'h0, 8'h08, 32'h0000_0009, relay_cfg_pkg::RESP_OKAY}};

  field_side_model u_field_side_model (.keep_sel_in(keep), .ident_value_in(ident), .drive_pos_in(pos),
    .drive_neg_in(neg), .jumper_out(jmp), .switch_out(sw), .term_a_out(ta), .term_b_out(tb));
  relay_card_ctrl u_relay_card_ctrl (.mclk_in(mclk_in), .resetn_in(resetn_in), .host_resetn_in(host_resetn_in),
    .reset_retention_jumper_in(jmp), .card_identity_switch_in(sw), .isolated_input_terminal_a_in(ta),
    .isolated_input_terminal_b_in(tb), .relay_normally_open_contact_out(no_o),
    .relay_normally_closed_contact_out(nc_o), .awaddr_in(awaddr), .awvalid_in(awvalid),
    .awready_out(awready), .wdata_in(wdata), .wstrb_in(4'hF), .wvalid_in(wvalid), .wready_out(wready),
    .bresp_out(bresp), .bvalid_out(bvalid), .bready_in(bready), .araddr_in(araddr), .arvalid_in(arvalid),
    .arready_out(arready), .rdata_out(rdata), .rresp_out(rresp), .rvalid_out(rvalid), .rready_in(rready));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk_relay(input logic [7:0] exp);
    chk({24'h0, no_o}, {24'h0, exp});
    chk({24'h0, nc_o}, {24'h0, ~exp});
  endtask

  // ready is looked at just before the edge, so the edge's own updates cannot race it
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] dt, output logic [1:0] rs);
    logic ha, hw, hb, done;
    done = 1'b0;
    awaddr <= a;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(negedge mclk_in);
      ha = awvalid && awready === 1'b1;
      hw = wvalid && wready === 1'b1;
      hb = bvalid === 1'b1;
      rs = bresp;
      @(posedge mclk_in);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
      done = hb;
    end
    // idle edge, so a following call never re-raises bready in this time step
    @(posedge mclk_in);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rs);
    logic ha, hr, done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(negedge mclk_in);
      ha = arvalid && arready === 1'b1;
      hr = rvalid === 1'b1;
      dt = rdata;
      rs = rresp;
      @(posedge mclk_in);
      if (ha) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
      done = hr;
    end
    // idle edge, so a following call never re-raises rready in this time step
    @(posedge mclk_in);
  endtask

  task automatic host_reset;
    host_resetn_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    host_resetn_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk_in);
    err_total++;
    end_of_test();
  end

  initial begin
    resetn_in = 1'b0;
    host_resetn_in = 1'b1;
    keep = 1'b0;
    ident = 4'h9;
    pos = 8'h00;
    neg = 8'h00;
    {awaddr, araddr, wdata} = 48'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    err_total = 0;
    checks = 0;
    repeat (6) @(posedge mclk_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    chk_relay(8'h00);
    for (i = 0; i < 8; i++) begin
      if (rows[i].wr) begin
        axi_wr(rows[i].addr, rows[i].data, r);
      end else begin
        axi_rd(rows[i].addr, d, r);
        chk(d, rows[i].data);
      end
      chk({30'h0, r}, {30'h0, rows[i].resp});
    end
    chk_relay(8'hA5);
    for (i = 0; i < 16; i++) begin
      ident <= 4'(i);
      repeat (4) @(posedge mclk_in);
      axi_rd(8'h08, d, r);
      chk(d, 32'(i));
    end
    pos <= 8'h03;
    neg <= 8'h30;
    repeat (4) @(posedge mclk_in);
    axi_rd(8'h04, d, r);
    chk(d, 32'h0000_0033);
    axi_wr(8'h10, 32'h0000_00FF, r);
    pos <= 8'h0C;
    neg <= 8'hC0;
    repeat (5) @(posedge mclk_in);
    axi_rd(8'h10, d, r);
    chk(d, 32'h0000_00C3);
    axi_wr(8'h10, 32'h0000_00C3, r);
    axi_rd(8'h10, d, r);
    chk(d, 32'h0000_0000);
    host_reset();
    chk_relay(8'h00);
    axi_rd(8'h0C, d, r);
    chk(d, 32'h0000_0000);
    keep <= 1'b1;
    axi_wr(8'h00, 32'h0000_003C, r);
    repeat (3) @(posedge mclk_in);
    host_reset();
    chk_relay(8'h3C);
    resetn_in <= 1'b0;
    repeat (6) @(posedge mclk_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    chk_relay(8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
